// ### hw/sas_consts.svh
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH

// Register byte offsets on the bus
`define SAS_OFS_CTRL 4'h0
`define SAS_OFS_REFSEL 4'h4
`define SAS_OFS_STATUS 4'h8
`define SAS_OFS_RESULT 4'hC

// Control register fields
`define SAS_CTRL_START 0
`define SAS_CTRL_CONT 1
`define SAS_CTRL_CH_LO 4
`define SAS_CTRL_CH_HI 7

// Status register fields
`define SAS_STAT_BUSY 0
`define SAS_STAT_DONE 1

// Reference select fields
`define SAS_REF_LO_LO 0
`define SAS_REF_LO_HI 3
`define SAS_REF_UP_LO 4
`define SAS_REF_UP_HI 7

// Reset values
`define SAS_RST_REFSEL 8'h00
`define SAS_RST_CH 4'h0
`define SAS_RST_CODE 8'h00

// Conversion timing in machine cycles, first trial bit and channel count
`define SAS_SAMPLE_MC 4'd7
`define SAS_TOTAL_MC 4'd13
`define SAS_MSB_IDX 3'd7
`define SAS_TRIAL_MSB 8'h80
`define SAS_NUM_CH 4'd12

`endif

// ### hw/sas_pkg.sv
`default_nettype none

package sas_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {
    SAS_IDLE,
    SAS_SAMPLE,
    SAS_CONVERT,
    SAS_HOLD
  } sas_phase_t;

  // Whole state of the sequencer
  typedef struct packed {
    sas_phase_t phase;
    logic [7:0] div_cnt;
    logic [3:0] mc_cnt;
    logic [7:0] settle_cnt;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] result;
    logic cont_mode;
    logic [3:0] channel;
    logic [7:0] refsel;
    logic done_flag;
    logic ack;
    logic [31:0] rdata;
    logic done_pulse;
  } sas_state_t;

endpackage

`default_nettype wire

// ### hw/sas_sequencer.sv
// What this block does
// (RULE1) Eight-bit successive approximation, twelve muxed inputs
// (RULE2) Sample phase lasts exactly seven machine cycles
// (RULE3) Whole conversion takes thirteen machine cycles
// (RULE4) Single mode stops; continuous mode restarts
// (RULE5) End of conversion raises a request
// (RULE6) Upper, lower references each sixteen steps
// (RULE7) Result range spans selected internal references
// (RULE8) Low nibble lower step, high upper
`include "sas_consts.svh"
`default_nettype none

module sas_sequencer
  import sas_pkg::*;
#(
  parameter int CLKS_PER_MC = 12, // System clocks per machine cycle
  parameter int BIT_CLKS = 8 // Settle clocks per trial bit
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] mux_sel,
  output logic sample_en,
  output logic [7:0] trial_code,
  input wire logic comp_above,
  output logic [3:0] internal_upper_reference,
  output logic [3:0] internal_lower_reference,
  output logic conv_done_req,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State and derived constants

  sas_state_t st_reg; // Registered state
  sas_state_t st_next; // Next state

  // Both wraps are cut to the counter width on purpose
  localparam logic [7:0] MC_LAST = 8'(CLKS_PER_MC - 1); // Divider wrap
  localparam logic [7:0] BIT_LAST = 8'(BIT_CLKS - 1); // Settle wrap

  logic mc_tick; // One-cycle machine cycle enable
  logic bus_req; // Any bus request pending
  logic bus_take; // Request completes this edge
  logic wr_ctrl; // Control register write accepted
  logic start_req; // Software start
  logic rd_result; // Result register read accepted
  logic conv_end; // Last machine cycle of conversion
  logic [3:0] ch_wr; // Channel field written

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers

  // Divider pulse marks each machine cycle boundary
  assign mc_tick = (st_reg.div_cnt == MC_LAST);
  assign bus_req = avs_read | avs_write;
  // One wait state: answer after the registered acknowledge
  assign bus_take = bus_req & st_reg.ack;
  assign wr_ctrl = bus_take & avs_write & (avs_address == `SAS_OFS_CTRL);
  assign start_req = wr_ctrl & avs_writedata[`SAS_CTRL_START];
  assign rd_result = bus_take & avs_read & (avs_address == `SAS_OFS_RESULT);
  assign ch_wr = avs_writedata[`SAS_CTRL_CH_HI:`SAS_CTRL_CH_LO];
  // Thirteenth machine cycle closes the conversion
  assign conv_end = (st_reg.phase == SAS_HOLD) & mc_tick &
                    (st_reg.mc_cnt == (`SAS_TOTAL_MC - 4'd1)); // see (RULE3)

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_next = st_reg;
    st_next.done_pulse = 1'b0;

    // Bus acknowledge toggles so each request sees one wait state
    st_next.ack = bus_req & ~st_reg.ack;

    // Read data captured in the wait cycle, presented when waitrequest drops
    if (bus_req & ~st_reg.ack & avs_read) begin
      case (avs_address)
        `SAS_OFS_CTRL: begin
          st_next.rdata = {24'h00_0000, st_reg.channel, 2'b00, st_reg.cont_mode, 1'b0};
        end
        `SAS_OFS_REFSEL: begin
          st_next.rdata = {24'h00_0000, st_reg.refsel};
        end
        `SAS_OFS_STATUS: begin
          st_next.rdata = {30'h0000_0000, st_reg.done_flag, st_reg.phase != SAS_IDLE};
        end
        `SAS_OFS_RESULT: begin
          st_next.rdata = {24'h00_0000, st_reg.result};
        end
        default: begin
          // Unmapped reads return zero
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Register writes
    if (wr_ctrl) begin
      st_next.cont_mode = avs_writedata[`SAS_CTRL_CONT]; // see (RULE4)
      // Out-of-range channels are refused and the old one kept
      // A channel change in mid-conversion moves the mux at once
      if (ch_wr < `SAS_NUM_CH) begin
        st_next.channel = ch_wr; // see (RULE1)
      end
    end
    if (bus_take & avs_write & (avs_address == `SAS_OFS_REFSEL)) begin
      // Spans are stored as written; keeping them legal is up to software
      st_next.refsel = avs_writedata[`SAS_REF_UP_HI:`SAS_REF_LO_LO]; // see (RULE6)
    end

    // Machine cycle divider, free running unless a conversion is started
    st_next.div_cnt = mc_tick ? 8'h00 : st_reg.div_cnt + 8'h01;

    // Done flag clears on result read; a new completion wins
    if (rd_result) begin
      st_next.done_flag = 1'b0;
    end

    // Conversion sequencing
    case (st_reg.phase)
      SAS_IDLE: begin
        // Start aligns the divider so the phase lengths are exact
        if (start_req) begin
          st_next.phase = SAS_SAMPLE;
          st_next.div_cnt = 8'h00;
          st_next.mc_cnt = 4'h0;
        end
      end
      SAS_SAMPLE: begin
        if (mc_tick) begin
          st_next.mc_cnt = st_reg.mc_cnt + 4'h1;
          // Seventh machine cycle ends the sample window
          if (st_reg.mc_cnt == (`SAS_SAMPLE_MC - 4'd1)) begin // see (RULE2)
            st_next.phase = SAS_CONVERT;
            st_next.bit_idx = `SAS_MSB_IDX;
            st_next.trial = `SAS_TRIAL_MSB;
            st_next.settle_cnt = 8'h00;
          end
        end
      end
      // Limitation: all eight trials must fit in six machine cycles
      SAS_CONVERT: begin
        if (mc_tick) begin
          st_next.mc_cnt = st_reg.mc_cnt + 4'h1;
        end
        // One trial bit per settle interval, MSB first
        if (st_reg.settle_cnt == BIT_LAST) begin
          st_next.settle_cnt = 8'h00;
          if (!comp_above) begin
            st_next.trial[st_reg.bit_idx] = 1'b0; // see (RULE1)
          end
          if (st_reg.bit_idx == 3'd0) begin
            st_next.phase = SAS_HOLD;
          end else begin
            st_next.bit_idx = st_reg.bit_idx - 3'd1;
            st_next.trial[st_reg.bit_idx - 3'd1] = 1'b1;
          end
        end else begin
          st_next.settle_cnt = st_reg.settle_cnt + 8'h01;
        end
      end
      SAS_HOLD: begin
        // Result withheld until the full conversion time has passed
        if (mc_tick) begin
          st_next.mc_cnt = st_reg.mc_cnt + 4'h1;
        end
        if (conv_end) begin
          st_next.result = st_reg.trial; // see (RULE3)
          st_next.done_flag = 1'b1; // see (RULE5)
          st_next.done_pulse = 1'b1; // see (RULE5)
          st_next.mc_cnt = 4'h0;
          // Continuous mode restarts on the next machine cycle at once
          st_next.phase = st_reg.cont_mode ? SAS_SAMPLE : SAS_IDLE; // see (RULE4)
        end
      end
      default: begin
        st_next.phase = SAS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.phase <= SAS_IDLE;
      st_reg.refsel <= `SAS_RST_REFSEL;
      st_reg.channel <= `SAS_RST_CH;
      st_reg.result <= `SAS_RST_CODE;
      st_reg.trial <= `SAS_RST_CODE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Combinational handshake, so the single wait state costs no extra cycle
  assign avs_waitrequest = bus_req & ~st_reg.ack;
  assign avs_readdata = st_reg.rdata;
  assign mux_sel = st_reg.channel;
  assign sample_en = (st_reg.phase == SAS_SAMPLE); // see (RULE2)
  assign trial_code = st_reg.trial;
  // Ladder spreads the code range over the selected span
  assign internal_lower_reference = st_reg.refsel[`SAS_REF_LO_HI:`SAS_REF_LO_LO]; // see (RULE7)
  assign internal_upper_reference = st_reg.refsel[`SAS_REF_UP_HI:`SAS_REF_UP_LO]; // see (RULE8)
  assign conv_done_req = st_reg.done_pulse;
  // Busy follows the phase, so it rises in the same cycle as sample_en
  assign busy = (st_reg.phase != SAS_IDLE);

endmodule

`default_nettype wire

// ### tb/sas_sequencer_properties.sv
`default_nettype none
//////////////////////////////////////////////////////////////
module sas_sequencer_props #(
  parameter int CLKS_PER_MC = 12,
  parameter int BIT_CLKS = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] mux_sel,
  input wire logic sample_en,
  input wire logic [7:0] trial_code,
  input wire logic [3:0] internal_upper_reference,
  input wire logic [3:0] internal_lower_reference,
  input wire logic conv_done_req
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TOT = 13 * CLKS_PER_MC; // Start to result, in clocks
  logic [7:0] smp_reg; // Clocks of sample_en so far
  logic req; // Any bus request
  assign req = avs_read | avs_write;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Counter, since the sample window is too long for a repetition
  always_ff @(posedge clk_sys) smp_reg <= (srst || !sample_en) ? 8'h00 : smp_reg + 8'h01;
  property p_idle; !req |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait without request");
  property p_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("more than one wait state");
  property p_smp; $fell(sample_en) |-> smp_reg == 7 * CLKS_PER_MC; endproperty
  a_smp: assert property (p_smp) else $error("sample length wrong");
  property p_tot; $rose(sample_en) |-> ##TOT conv_done_req; endproperty
  a_tot: assert property (p_tot) else $error("conversion length wrong");
  property p_pulse; conv_done_req |=> !conv_done_req; endproperty
  a_pulse: assert property (p_pulse) else $error("done request too long");
  property p_msb; $fell(sample_en) |-> trial_code == 8'h80; endproperty
  a_msb: assert property (p_msb) else $error("first trial not MSB");
  property p_ref; avs_write && !avs_waitrequest && avs_address == 4'h4 |=>
    {internal_upper_reference, internal_lower_reference} == $past(avs_writedata[7:0]); endproperty
  a_ref: assert property (p_ref) else $error("reference steps not taken");
  property p_ch; mux_sel < 4'd12; endproperty
  a_ch: assert property (p_ch) else $error("channel out of range");
  property p_unm; avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00 |->
    avs_readdata == 32'h0000_0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
bind sas_sequencer sas_sequencer_props #(.CLKS_PER_MC(CLKS_PER_MC), .BIT_CLKS(BIT_CLKS))
  i_sas_sequencer_props (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .mux_sel(mux_sel), .sample_en(sample_en),
  .trial_code(trial_code), .internal_upper_reference(internal_upper_reference),
  .internal_lower_reference(internal_lower_reference), .conv_done_req(conv_done_req)
);
`default_nettype wire

// ### tb/sas_analog_model.sv
`default_nettype none
//////////////////////////////////////////////////////////////
module sas_analog_model (
  input wire logic clk_sys,
  input wire logic [3:0] mux_sel,
  input wire logic sample_en,
  input wire logic [7:0] trial_code,
  output logic comp_above
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held_reg; // Level frozen by the sample switch
  // Channel n carries level n*16+9; tracked only while sampling
  always_ff @(posedge clk_sys) if (sample_en) held_reg <= {mux_sel, 4'h9};
  // Comparator: high while the trial is at or below the input
  assign comp_above = held_reg >= trial_code;
endmodule
`default_nettype wire

// ### tb/test_sas_sequencer.sv
`default_nettype none
//////////////////////////////////////////////////////////////
module test_sas_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, comp_above;
  logic sample_en, conv_done_req, busy;
  logic [3:0] avs_address, mux_sel, internal_upper_reference, internal_lower_reference;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] trial_code;
  int n_fail, checks;
  // Short machine cycle keeps the run brief
  sas_sequencer #(.CLKS_PER_MC(4), .BIT_CLKS(2)) i_sas_sequencer (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mux_sel(mux_sel), .sample_en(sample_en),
    .trial_code(trial_code), .comp_above(comp_above),
    .internal_upper_reference(internal_upper_reference),
    .internal_lower_reference(internal_lower_reference),
    .conv_done_req(conv_done_req), .busy(busy)
  );
  sas_analog_model i_sas_analog_model (
    .clk_sys(clk_sys), .mux_sel(mux_sel), .sample_en(sample_en), .trial_code(trial_code),
    .comp_above(comp_above)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus cycle; request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wait_done;
    repeat (200) begin
      @(negedge clk_sys);
      if (conv_done_req === 1'b1) break;
    end
    chk(conv_done_req, 32'h0000_0001);
  endtask
  // Reset values and unmapped places
  task t_reset;
    bus(1'b1, 4'h6, 32'h0000_00FF);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask
  // Lower reference steps 0 to 12 with the upper at 0, then upper steps 4 to 15 with the lower at 0
  task t_ref;
    logic [7:0] c;
    for (int i = 0; i < 25; i++) begin
      c = (i < 13) ? {4'h0, 4'(i)} : {4'(i - 9), 4'h0};
      bus(1'b1, 4'h4, {24'h0000_00, c});
      bus(1'b0, 4'h4, 32'h0000_0000);
      chk(q, {24'h0000_00, c});
      chk({internal_upper_reference, internal_lower_reference}, c);
    end
  endtask
  // Single conversion, then a refused channel
  task t_single;
    bus(1'b1, 4'h0, 32'h0000_0051);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0050);
    wait_done;
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(q, 32'h0000_0059);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_00C0);
    @(negedge clk_sys);
    chk(mux_sel, 32'h0000_0005);
  endtask
  // Continuous mode restarts until it is cleared
  task t_cont;
    bus(1'b1, 4'h0, 32'h0000_0033);
    wait_done;
    wait_done;
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk(q, 32'h0000_0039);
    bus(1'b1, 4'h0, 32'h0000_0030);
    wait_done;
    repeat (60) @(negedge clk_sys);
    chk(busy, 32'h0000_0000);
  endtask
  task results;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    n_fail = 0;
    checks = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_ref;
    t_single;
    t_cont;
    results;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    results;
  end
endmodule
`default_nettype wire
